// file: src/mmsc_pkg.sv
// shared constants, modes and helpers for the memory map and security block
package mmsc_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_RAM_POS = 8'h10;
  localparam logic [7:0] IDX_REG_POS = 8'h11;
  localparam logic [7:0] IDX_CAL_POS = 8'h12;
  localparam logic [7:0] IDX_MISC = 8'h13;
  localparam logic [11:0] ADDR_RAM_POS = {2'h0, IDX_RAM_POS, 2'h0};
  localparam logic [11:0] ADDR_REG_POS = {2'h0, IDX_REG_POS, 2'h0};
  localparam logic [11:0] ADDR_CAL_POS = {2'h0, IDX_CAL_POS, 2'h0};
  localparam logic [11:0] ADDR_MISC = {2'h0, IDX_MISC, 2'h0};

  // values after reset
  localparam logic [7:0] RST_RAM_POS = 8'h09;
  localparam logic [7:0] RST_REG_POS = 8'h00;
  localparam logic [7:0] RST_CAL_POS = 8'h11;
  localparam logic [1:0] RST_STRETCH = 2'h3;
  localparam logic RST_UPPER_ONLY = 1'b0;
  localparam logic [2:0] RST_MODE = 3'h4;

  // field positions
  localparam int RAM_FIELD_LSB = 3;
  localparam int REG_FIELD_LSB = 3;
  localparam int CAL_FIELD_LSB = 3;
  localparam int STRETCH_LSB = 2;
  localparam int UPPER_ONLY_BIT = 1;
  localparam int FLASH_EN_BIT = 0;
  localparam int HIGH_ALIGN_BIT = 0;
  localparam int CAL_EN_BIT = 0;

  // operating mode codes as strapped on the mode pins
  localparam logic [2:0] MODE_SSC = 3'h0;
  localparam logic [2:0] MODE_EMU_NARROW = 3'h1;
  localparam logic [2:0] MODE_TEST = 3'h2;
  localparam logic [2:0] MODE_EMU_WIDE = 3'h3;
  localparam logic [2:0] MODE_NSC = 3'h4;
  localparam logic [2:0] MODE_NEXP_NARROW = 3'h5;
  localparam logic [2:0] MODE_PERIPH = 3'h6;
  localparam logic [2:0] MODE_NEXP_WIDE = 3'h7;

  // address map constants
  localparam logic [7:0] DEBUG_PAGE = 8'hff;
  localparam logic [5:0] PAGE_LOW = 6'h3d;
  localparam logic [5:0] PAGE_MID = 6'h3e;
  localparam logic [5:0] PAGE_WINDOW = 6'h3c;
  localparam logic [5:0] PAGE_TOP = 6'h3f;

  typedef enum logic [1:0] {BOOT_SYNC1, BOOT_SYNC2, BOOT_LOAD, BOOT_RUN}
    mmsc_boot_e;

  function automatic logic is_special(input logic [2:0] m);
    return (m == MODE_SSC) || (m == MODE_TEST) || (m == MODE_PERIPH);
  endfunction

  function automatic logic is_expanded(input logic [2:0] m);
    return m[0];
  endfunction

  function automatic logic is_emulation(input logic [2:0] m);
    return (m == MODE_EMU_NARROW) || (m == MODE_EMU_WIDE);
  endfunction

endpackage

// file: src/mmsc_sec_decode.sv
// decoder of the two non-volatile security bits
module mmsc_sec_decode
  import mmsc_pkg::*;
(
  input wire logic security_bit_high,
  input wire logic security_bit_low,
  output logic secured
);

  // only high set, low clear leaves the part open
  assign secured = !(security_bit_high && !security_bit_low);

endmodule // mmsc_sec_decode

// file: src/mmsc_stretch.sv
// stretch counter for accesses that go to the external bus
module mmsc_stretch
  import mmsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic enable,
  input wire logic [1:0] stretch,
  output logic busy
);

  logic [1:0] count;
  logic [1:0] next_count;

  // load on a new access when idle, then count down
  always_comb begin
    next_count = count;
    if (start && enable && count == 2'h0) begin
      next_count = stretch;
    end else if (count != 2'h0) begin
      next_count = count - 2'h1;
    end
  end

  // counter and busy flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 2'h0;
      busy <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_count != 2'h0;
    end
  end

  a_stretch_three: assert property (@(posedge pclk) disable iff (!presetn)
    (start && enable && count == 2'h0 && stretch == 2'h3)
      |=> busy [*3] ##1 !busy)
    else $error("three cycle stretch wrong");

  a_stretch_off: assert property (@(posedge pclk) disable iff (!presetn)
    (!enable && count == 2'h0) |=> !busy)
    else $error("stretch active outside expanded mode");

endmodule // mmsc_stretch

// file: src/mmsc_top.sv
// memory map, select decode and security control with apb registers
//
// The APB register port was chosen for this implementation.
module mmsc_top
  import mmsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [2:0] mode_pins,
  input wire logic expansion_config_pin,
  input wire logic security_bit_high,
  input wire logic security_bit_low,
  input wire logic [15:0] core_addr,
  input wire logic core_access,
  input wire logic core_read,
  input wire logic [15:0] cal_rdata,
  input wire logic debug_active,
  output logic sel_debug,
  output logic sel_register,
  output logic sel_ram,
  output logic sel_cal,
  output logic sel_flash,
  output logic sel_external,
  output logic periph_sel,
  output logic [5:0] flash_page,
  output logic [15:0] cal_read_data,
  output logic secured,
  output logic debug_port_enable,
  output logic erase_verify_start,
  output logic ext_stretch_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and boot sequence

  logic [2:0] mode_meta;
  logic [2:0] mode_sync;
  logic pin_meta;
  logic pin_sync;
  logic sec_hi_meta;
  logic sec_hi_sync;
  logic sec_lo_meta;
  logic sec_lo_sync;
  logic sec_dec;
  mmsc_boot_e boot;
  logic [2:0] mode_q;
  logic secured_exp;

  // two flops on every strap and security input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_meta <= RST_MODE;
      mode_sync <= RST_MODE;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      sec_hi_meta <= 1'b0;
      sec_hi_sync <= 1'b0;
      sec_lo_meta <= 1'b0;
      sec_lo_sync <= 1'b0;
    end else begin
      mode_meta <= mode_pins;
      mode_sync <= mode_meta;
      pin_meta <= expansion_config_pin;
      pin_sync <= pin_meta;
      sec_hi_meta <= security_bit_high;
      sec_hi_sync <= sec_hi_meta;
      sec_lo_meta <= security_bit_low;
      sec_lo_sync <= sec_lo_meta;
    end
  end

  mmsc_sec_decode u_sec (
    .security_bit_high(sec_hi_sync),
    .security_bit_low(sec_lo_sync),
    .secured(sec_dec)
  );

  // wait for the synchronisers, capture once, then run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot <= BOOT_SYNC1;
    end else begin
      unique case (boot)
        BOOT_SYNC1: boot <= BOOT_SYNC2;
        BOOT_SYNC2: boot <= BOOT_LOAD;
        BOOT_LOAD: boot <= BOOT_RUN;
        BOOT_RUN: boot <= BOOT_RUN;
      endcase
    end
  end

  // security and mode caught after each reset release, safe until then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secured <= 1'b1;
      mode_q <= RST_MODE;
      secured_exp <= 1'b1;
      erase_verify_start <= 1'b0;
    end else begin
      erase_verify_start <= 1'b0;
      if (boot == BOOT_LOAD) begin
        secured <= sec_dec;
        mode_q <= mode_sync;
        secured_exp <= sec_dec && is_expanded(mode_sync);
        erase_verify_start <= mode_sync == MODE_SSC;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and registers

  logic apb_fire;
  logic wr_ram;
  logic wr_reg;
  logic wr_cal;
  logic wr_misc;
  logic [4:0] ram_field;
  logic ram_high_align;
  logic [3:0] reg_field;
  logic [4:0] cal_field;
  logic cal_enable;
  logic [1:0] external_stretch;
  logic flash_upper_half_only;
  logic flash_enable;
  logic ram_written;
  logic reg_written;
  logic misc_written;
  logic once_mode;
  logic [31:0] next_prdata;
  logic next_pslverr;

  assign apb_fire = psel && penable && pready;
  assign wr_ram = apb_fire && pwrite && paddr == ADDR_RAM_POS;
  assign wr_reg = apb_fire && pwrite && paddr == ADDR_REG_POS;
  assign wr_cal = apb_fire && pwrite && paddr == ADDR_CAL_POS;
  assign wr_misc = apb_fire && pwrite && paddr == ADDR_MISC;
  assign once_mode = !is_special(mode_q);

  // one wait state, held off until the straps are captured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready && boot == BOOT_RUN;
      if (psel && penable && !pready) begin
        prdata <= next_prdata;
        pslverr <= next_pslverr;
      end
    end
  end

  // read mux, unused bits read as zero, unmapped answers an error
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      ADDR_RAM_POS:
        next_prdata[7:0] = {ram_field, 2'h0, ram_high_align};
      ADDR_REG_POS: next_prdata[7:0] = {1'b0, reg_field, 3'h0};
      ADDR_CAL_POS: next_prdata[7:0] = {cal_field, 2'h0, cal_enable};
      ADDR_MISC: next_prdata[7:0] = {4'h0, external_stretch,
                                     flash_upper_half_only, flash_enable};
      default: next_pslverr = 1'b1;
    endcase
  end

  // ram position, write once outside special modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_field <= RST_RAM_POS[7:RAM_FIELD_LSB];
      ram_high_align <= RST_RAM_POS[HIGH_ALIGN_BIT];
      ram_written <= 1'b0;
    end else if (wr_ram && !(once_mode && ram_written)) begin
      ram_field <= pwdata[7:RAM_FIELD_LSB];
      ram_high_align <= pwdata[HIGH_ALIGN_BIT];
      ram_written <= 1'b1;
    end
  end

  // register block position, bit 7 always zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_field <= RST_REG_POS[6:REG_FIELD_LSB];
      reg_written <= 1'b0;
    end else if (wr_reg && !(once_mode && reg_written)) begin
      reg_field <= pwdata[6:REG_FIELD_LSB];
      reg_written <= 1'b1;
    end
  end

  // calibration ram position, writable any time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_field <= RST_CAL_POS[7:CAL_FIELD_LSB];
      cal_enable <= RST_CAL_POS[CAL_EN_BIT];
    end else if (wr_cal) begin
      cal_field <= pwdata[7:CAL_FIELD_LSB];
      cal_enable <= pwdata[CAL_EN_BIT];
    end
  end

  // misc controls, flash enable reset value follows mode and pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_stretch <= RST_STRETCH;
      flash_upper_half_only <= RST_UPPER_ONLY;
      flash_enable <= 1'b0;
      misc_written <= 1'b0;
    end else if (boot == BOOT_LOAD) begin
      if (mode_sync == MODE_TEST) begin
        flash_enable <= 1'b0;
      end else if (is_emulation(mode_sync)) begin
        flash_enable <= !pin_sync;
      end else if (is_expanded(mode_sync)) begin
        flash_enable <= pin_sync;
      end else begin
        flash_enable <= 1'b1;
      end
    end else if (wr_misc && !(once_mode && misc_written)) begin
      external_stretch <= pwdata[STRETCH_LSB +: 2];
      flash_upper_half_only <= pwdata[UPPER_ONLY_BIT];
      flash_enable <= pwdata[FLASH_EN_BIT];
      misc_written <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective mapping copies and select decode

  logic [4:0] eff_ram;
  logic [3:0] eff_reg;
  logic [4:0] eff_cal;
  logic eff_cal_en;
  logic [1:0] eff_stretch;
  logic eff_upper_only;
  logic eff_flash_en;
  logic next_sel_debug;
  logic next_sel_register;
  logic next_sel_ram;
  logic next_sel_cal;
  logic next_sel_flash;
  logic next_sel_external;
  logic [5:0] next_flash_page;
  logic hit_reg;
  logic hit_ram;
  logic hit_cal;
  logic hit_flash;

  // mapping follows the registers one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_ram <= RST_RAM_POS[7:RAM_FIELD_LSB];
      eff_reg <= RST_REG_POS[6:REG_FIELD_LSB];
      eff_cal <= RST_CAL_POS[7:CAL_FIELD_LSB];
      eff_cal_en <= RST_CAL_POS[CAL_EN_BIT];
      eff_stretch <= RST_STRETCH;
      eff_upper_only <= RST_UPPER_ONLY;
      eff_flash_en <= 1'b0;
    end else begin
      eff_ram <= ram_field;
      eff_reg <= reg_field;
      eff_cal <= cal_field;
      eff_cal_en <= cal_enable;
      eff_stretch <= external_stretch;
      eff_upper_only <= flash_upper_half_only;
      eff_flash_en <= flash_enable;
    end
  end

  // 1k registers, 2k ram and cal; lower flash half via pages 3d and 3e
  assign hit_reg = core_addr[15:10] == {1'b0, eff_reg, 1'b0};
  assign hit_ram = core_addr[15:11] == eff_ram;
  assign hit_cal = eff_cal_en && !secured_exp
                   && core_addr[15:11] == eff_cal;
  // upper only hides lower half; page window stays in the upper half
  assign hit_flash = eff_flash_en && !secured_exp
                     && !(eff_upper_only && !core_addr[15]);

  // single select by priority
  always_comb begin
    next_sel_debug = 1'b0;
    next_sel_register = 1'b0;
    next_sel_ram = 1'b0;
    next_sel_cal = 1'b0;
    next_sel_flash = 1'b0;
    next_sel_external = 1'b0;
    if (core_access) begin
      if (debug_active && core_addr[15:8] == DEBUG_PAGE) begin
        next_sel_debug = 1'b1;
      end else if (hit_reg) begin
        next_sel_register = 1'b1;
      end else if (hit_ram) begin
        next_sel_ram = 1'b1;
      end else if (hit_cal) begin
        next_sel_cal = 1'b1;
      end else if (hit_flash) begin
        next_sel_flash = 1'b1;
      end else if (is_expanded(mode_q)) begin
        next_sel_external = 1'b1;
      end
    end
  end

  // flash page seen by each quarter of the map
  always_comb begin
    unique case (core_addr[15:14])
      2'h0: next_flash_page = PAGE_LOW;
      2'h1: next_flash_page = PAGE_MID;
      2'h2: next_flash_page = PAGE_WINDOW;
      2'h3: next_flash_page = PAGE_TOP;
    endcase
  end

  // registered selects and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_debug <= 1'b0;
      sel_register <= 1'b0;
      sel_ram <= 1'b0;
      sel_cal <= 1'b0;
      sel_flash <= 1'b0;
      sel_external <= 1'b0;
      periph_sel <= 1'b0;
      flash_page <= PAGE_LOW;
      cal_read_data <= 16'h0000;
    end else begin
      sel_debug <= next_sel_debug;
      sel_register <= next_sel_register;
      sel_ram <= next_sel_ram;
      sel_cal <= next_sel_cal;
      sel_flash <= next_sel_flash;
      sel_external <= next_sel_external;
      periph_sel <= next_sel_register;
      flash_page <= next_flash_page;
      if (secured && mode_q == MODE_SSC && core_read) begin
        cal_read_data <= 16'hffff;
      end else begin
        cal_read_data <= cal_rdata;
      end
    end
  end

  // debug port refused while secured, except for erase verify firmware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_port_enable <= 1'b0;
    end else begin
      debug_port_enable <= !secured || mode_q == MODE_SSC;
    end
  end

  mmsc_stretch u_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .start(next_sel_external && !sel_external),
    .enable(is_expanded(mode_q) && mode_q != MODE_PERIPH),
    .stretch(eff_stretch),
    .busy(ext_stretch_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_sec_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (boot == BOOT_LOAD) |=> secured == $past(sec_dec))
    else $error("security not taken from bits");

  a_sec_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (boot == BOOT_RUN) |=> $stable(secured))
    else $error("security changed while running");

  a_cal_ones: assert property (@(posedge pclk) disable iff (!presetn)
    (secured && mode_q == MODE_SSC && core_read && next_sel_cal)
      |=> sel_cal && cal_read_data == 16'hffff)
    else $error("secured cal read not all ones");

  a_debug_block: assert property (@(posedge pclk) disable iff (!presetn)
    (boot == BOOT_RUN && secured && mode_q != MODE_SSC)
      |=> !debug_port_enable)
    else $error("debug port open while secured");

  a_exp_lockout: assert property (@(posedge pclk) disable iff (!presetn)
    (boot == BOOT_RUN && secured && is_expanded(mode_q))
      |=> !sel_flash && !sel_cal)
    else $error("flash or cal reachable secured expanded");

  a_erase_start: assert property (@(posedge pclk) disable iff (!presetn)
    (boot == BOOT_LOAD && mode_sync == MODE_SSC) |=> erase_verify_start
      ##1 !erase_verify_start)
    else $error("erase verify start missing");

  a_write_once: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ram && ram_written && once_mode) |=> $stable(ram_field))
    else $error("second ram position write accepted");

  a_map_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(reg_field) |-> $stable(eff_reg) ##1 eff_reg == $past(reg_field))
    else $error("mapping change not one cycle late");

  a_one_select: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0({sel_debug, sel_register, sel_ram, sel_cal, sel_flash,
              sel_external}))
    else $error("more than one select active");

endmodule // mmsc_top

// file: test/mmsc_core_model.sv
// cpu core bus master model for the core address side
module mmsc_core_model (
  input wire logic pclk,
  output logic [15:0] core_addr,
  output logic core_access,
  output logic core_read,
  output logic [15:0] cal_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idle at time zero
  initial begin
    core_addr = 16'h0000;
    core_access = 1'b0;
    core_read = 1'b0;
  end

  // cal array data tracks the address so stale data shows
  assign cal_rdata = core_addr ^ 16'h5a5a;

  // one access, held until the edge that samples it
  task automatic go(input logic [15:0] a, input logic rd);
    @(posedge pclk);
    core_addr <= a;
    core_access <= 1'b1;
    core_read <= rd;
    @(posedge pclk);
    #1;
  endtask

  // release the bus at the next edge
  task automatic idle();
    @(posedge pclk);
    core_access <= 1'b0;
    core_read <= 1'b0;
  endtask
endmodule // mmsc_core_model

// file: test/mmsc_top_tb.sv
// self-checking bench for the memory map and security block
module mmsc_top_tb
  import mmsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] mode_pins = MODE_NSC;
  logic expansion_config_pin = 1'b0;
  logic security_bit_high = 1'b1;
  logic security_bit_low = 1'b0;
  logic debug_active = 1'b0;
  logic pready, pslverr, sel_debug, sel_register, sel_ram, sel_cal;
  logic sel_flash, sel_external, periph_sel, secured, debug_port_enable;
  logic erase_verify_start, ext_stretch_busy, core_access, core_read;
  logic [31:0] prdata;
  logic [15:0] core_addr, cal_rdata, cal_read_data;
  logic [5:0] flash_page;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic ev_seen = 1'b0;

  always #2 pclk = ~pclk;

  mmsc_top u_mmsc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .mode_pins, .expansion_config_pin,
    .security_bit_high, .security_bit_low, .core_addr, .core_access,
    .core_read, .cal_rdata, .debug_active, .sel_debug, .sel_register,
    .sel_ram, .sel_cal, .sel_flash, .sel_external, .periph_sel, .flash_page,
    .cal_read_data, .secured, .debug_port_enable, .erase_verify_start,
    .ext_stretch_busy);

  mmsc_core_model u_core (.pclk, .core_addr, .core_access, .core_read,
    .cal_rdata);

  // hang guard and erase-verify pulse catcher
  always @(posedge pclk) begin
    cycles++;
    if (erase_verify_start === 1'b1) ev_seen <= 1'b1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // apb transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] x, output logic [31:0] d,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, x};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // no local limit: only the bench's cycle ceiling ends a hung wait
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, x, d, e);
  endtask

  // read and compare, error flag folded into bit 31
  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [7:0] x);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 8'h00, d, e);
    chk(nm, {e, d[30:0]}, {24'h0, x});
  endtask

  task automatic rst(input logic [2:0] m, input logic p, h, l);
    u_core.idle();
    presetn <= 1'b0;
    mode_pins <= m;
    expansion_config_pin <= p;
    security_bit_high <= h;
    security_bit_low <= l;
    ev_seen = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  // one core access, selects as {dbg,reg,ram,cal,flash,ext}
  task automatic sel(input logic [15:0] a, input logic [5:0] e);
    u_core.go(a, 1'b0);
    chk("selects", {26'h0, sel_debug, sel_register, sel_ram, sel_cal,
        sel_flash, sel_external}, {26'h0, e});
  endtask

  task automatic busyn(input int x);
    int n;
    n = 0;
    repeat (8) begin
      if (ext_stretch_busy === 1'b1) n++;
      u_core.idle();
      #1;
    end
    chk("stretch cycles", n, x);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    logic [31:0] d;
    logic e;
    rdc("ram_position", ADDR_RAM_POS, 8'h09);
    rdc("register_block_position", ADDR_REG_POS, 8'h00);
    rdc("calibration_ram_position", ADDR_CAL_POS, 8'h11);
    rdc("extra_system_control", ADDR_MISC, 8'h0d);
    apb(1'b1, 12'h050, 8'h5a, d, e);
    chk("unmapped error", 32'(e), 32'h1);
  endtask

  task automatic s_map();
    sel(16'h4100, 6'h02);
    chk("flash_page", 32'(flash_page), 32'h3e);
    sel(16'h2000, 6'h02);
    chk("flash_page", 32'(flash_page), 32'h3d);
    sel(16'h0010, 6'h10);
    chk("periph_sel", 32'(periph_sel), 32'h1);
    sel(16'h0900, 6'h08);
    sel(16'h1000, 6'h04);
    @(posedge pclk) debug_active <= 1'b1;
    sel(16'hff10, 6'h20);
    @(posedge pclk) debug_active <= 1'b0;
    wr(ADDR_CAL_POS, 8'h10);
    sel(16'h1000, 6'h02);
    wr(ADDR_MISC, 8'h0f);
    sel(16'h4100, 6'h00);
    sel(16'h8100, 6'h02);
    wr(ADDR_RAM_POS, 8'h01);
    sel(16'h0010, 6'h10);
    sel(16'h0500, 6'h08);
    wr(ADDR_RAM_POS, 8'h21);
    rdc("ram_position", ADDR_RAM_POS, 8'h01);
    sel(16'h0500, 6'h08);
    wr(ADDR_REG_POS, 8'h08);
    sel(16'h0900, 6'h10);
    wr(ADDR_REG_POS, 8'h78);
    rdc("register_block_position", ADDR_REG_POS, 8'h08);
  endtask

  task automatic s_sec();
    for (int i = 0; i < 4; i++) begin
      rst(MODE_NSC, 1'b0, i[1], i[0]);
      chk("secured", 32'(secured), 32'(i != 2));
      chk("debug enable", 32'(debug_port_enable), 32'(i == 2));
    end
  endtask

  task automatic s_ssc();
    rst(MODE_SSC, 1'b0, 1'b0, 1'b0);
    chk("erase verify", 32'(ev_seen), 32'h1);
    chk("secured", 32'(secured), 32'h1);
    u_core.go(16'h1000, 1'b1);
    chk("cal data", 32'(cal_read_data), 32'hffff);
    rdc("extra_system_control", ADDR_MISC, 8'h0d);
    rst(MODE_SSC, 1'b0, 1'b1, 1'b0);
    u_core.go(16'h1000, 1'b1);
    chk("cal data", 32'(cal_read_data), 32'h4a5a);
    rst(MODE_TEST, 1'b0, 1'b1, 1'b0);
    rdc("extra_system_control", ADDR_MISC, 8'h0c);
  endtask

  task automatic s_ext();
    rst(MODE_NEXP_WIDE, 1'b1, 1'b0, 1'b0);
    rdc("extra_system_control", ADDR_MISC, 8'h0d);
    sel(16'h9000, 6'h01);
    sel(16'h1000, 6'h01);
    chk("debug enable", 32'(debug_port_enable), 32'h0);
    rst(MODE_NEXP_WIDE, 1'b0, 1'b1, 1'b0);
    rdc("extra_system_control", ADDR_MISC, 8'h0c);
    sel(16'h9000, 6'h01);
    busyn(3);
    wr(ADDR_MISC, 8'h04);
    sel(16'h9000, 6'h01);
    busyn(1);
    wr(ADDR_MISC, 8'h0c);
    rdc("extra_system_control", ADDR_MISC, 8'h04);
    rst(MODE_EMU_WIDE, 1'b1, 1'b1, 1'b0);
    rdc("extra_system_control", ADDR_MISC, 8'h0c);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst(MODE_NSC, 1'b0, 1'b1, 1'b0);
    s_regs();
    s_map();
    s_sec();
    s_ssc();
    s_ext();
    tally_and_finish();
  end
endmodule // mmsc_top_tb
